// >>> include/tpw_pkg.sv
package tpw_pkg;
  // Shared timebase geometry
  localparam int TB_HI_W  = 8;
  localparam int TB_LO_W  = 2;
  localparam int DUTY_W   = 10;
  localparam int PRESC_W  = 6;
  localparam int POST_W   = 4;
  localparam int NUM_CH   = 2;

  // Register byte addresses
  localparam logic [7:0] ADDR_PERIOD   = 8'h00;
  localparam logic [7:0] ADDR_TB_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_TB_COUNT = 8'h08;
  localparam logic [7:0] ADDR_FLAG     = 8'h0C;
  localparam logic [7:0] ADDR_CH_BASE  = 8'h10;
  localparam logic [7:0] CH_STRIDE     = 8'h10;
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DUTY_HI   = 8'h04;
  localparam logic [7:0] OFS_DUTY_LO   = 8'h08;

  // Field positions
  localparam int PRESC_LSB = 0;
  localparam int PRESC_MSB = 1;
  localparam int RUN_BIT   = 2;
  localparam int POST_LSB  = 3;
  localparam int POST_MSB  = 6;
  localparam int FLAG_BIT  = 0;
  localparam int INV_BIT   = 4;
  localparam int STATE_BIT = 5;
  localparam int EN_BIT    = 7;
  localparam int DLO_LSB   = 6;
  localparam int DLO_MSB   = 7;

  // Reset values
  localparam logic [7:0] PERIOD_RST  = 8'hFF;
  localparam logic [7:0] TB_CTRL_RST = 8'h00;
  localparam logic [7:0] CH_CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST    = 8'h00;

  // Prescale select 1:1, 1:4, 1:16, 1:64 as terminal count
  function automatic logic [PRESC_W-1:0] presc_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    return 6'h00;
      2'h1:    return 6'h03;
      2'h2:    return 6'h0F;
      default: return 6'h3F;
    endcase
  endfunction
endpackage

// >>> include/tpw_tb_if.sv
`timescale 1ns/1ps
interface tpw_tb_if;
  logic                        tick;
  logic                        start;
  logic [tpw_pkg::DUTY_W-1:0] count;
  modport src (output tick, output start, output count);
  modport snk (input tick, input start, input count);
endinterface

// >>> core/tpw_timebase.sv
`timescale 1ns/1ps
module tpw_timebase (
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         srst_in,
  // Control
  input  wire logic                         run_in,
  input  wire logic [1:0]                   presc_sel_in,
  input  wire logic [tpw_pkg::TB_HI_W-1:0]  period_in,
  // Timebase to channels
  tpw_tb_if.src                             tb
);
  logic [tpw_pkg::PRESC_W-1:0] presc_cnt;
  logic [tpw_pkg::PRESC_W-1:0] next_presc_cnt;
  logic [tpw_pkg::DUTY_W-1:0]  count;
  logic [tpw_pkg::DUTY_W-1:0]  next_count;
  logic                        tick;
  logic                        start;

  // Prescaled system clock drives the two low bits
  // At or past the limit, so a smaller prescale set while running takes effect at once
  assign tick  = run_in && (presc_cnt >= tpw_pkg::presc_limit(presc_sel_in));
  assign start = tick && (count == {period_in, 2'h3});

  always_comb begin
    next_presc_cnt = presc_cnt;
    next_count     = count;
    if (run_in) begin
      next_presc_cnt = tick ? '0 : presc_cnt + 6'h01;
    end
    if (start) begin
      next_count = '0;
    end else if (tick) begin
      next_count = count + 10'h001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      presc_cnt <= '0;
      count     <= '0;
    end else begin
      presc_cnt <= next_presc_cnt;
      count     <= next_count;
    end
  end

  assign tb.tick  = tick;
  assign tb.start = start;
  assign tb.count = count;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  wrap_to_zero_a: assert property (start |=> count == '0)
    else $error("timebase did not clear after period match");
  stopped_hold_a: assert property (!run_in |=> $stable(count))
    else $error("timebase moved while stopped");
  unity_step_a: assert property (run_in && presc_sel_in == 2'h0 && $stable(presc_sel_in)
    |-> tick)
    else $error("1:1 prescale missed a system clock");
endmodule

// >>> core/tpw_channel.sv
`timescale 1ns/1ps
module tpw_channel (
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         srst_in,
  // Channel settings
  input  wire logic                         enable_in,
  input  wire logic                         invert_in,
  input  wire logic [7:0]                   duty_high_in,
  input  wire logic [1:0]                   duty_low_in,
  input  wire logic [tpw_pkg::TB_HI_W-1:0]  period_in,
  // Shared timebase
  tpw_tb_if.snk                             tb,
  // Output
  output logic                              raw_out,
  output logic                              pwm_out
);
  logic [tpw_pkg::DUTY_W-1:0] duty_buf;
  logic [tpw_pkg::DUTY_W-1:0] next_duty_buf;
  logic                       raw;
  logic                       next_raw;
  logic                       pin;
  logic                       next_pin;
  logic                       reachable;

  // Duty beyond the last count never clears
  assign reachable = duty_buf <= {period_in, 2'h3};

  always_comb begin
    next_duty_buf = duty_buf;
    next_raw      = raw;
    if (tb.start) begin
      next_duty_buf = {duty_high_in, duty_low_in};
      next_raw      = (next_duty_buf != '0);
    end else if (tb.tick && reachable && (tb.count + 10'h001 == duty_buf)) begin
      next_raw = 1'b0;
    end
    if (!enable_in) begin
      next_raw = 1'b0;
    end
    next_pin = next_raw ^ invert_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      duty_buf <= '0;
      raw      <= 1'b0;
      pin      <= 1'b0;
    end else begin
      duty_buf <= next_duty_buf;
      raw      <= next_raw;
      pin      <= next_pin;
    end
  end

  assign raw_out = raw;
  assign pwm_out = pin;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_boundary_nonzero;
    tb.start && enable_in && ({duty_high_in, duty_low_in} != '0);
  endsequence

  set_at_start_a: assert property (s_boundary_nonzero |=> raw)
    else $error("output not active at period start");
  zero_duty_a: assert property (tb.start && {duty_high_in, duty_low_in} == '0
    |=> !raw)
    else $error("zero duty output went active");
  clear_on_match_a: assert property (tb.tick && !tb.start && reachable
    && tb.count + 10'h001 == duty_buf |=> !raw)
    else $error("output not cleared at duty match");
  full_duty_a: assert property (raw && enable_in && !tb.start && !reachable
    && $stable(enable_in) |=> raw)
    else $error("full duty output cleared");
  buffer_hold_a: assert property (!tb.start |=> $stable(duty_buf))
    else $error("duty buffer changed away from boundary");
  polarity_a: assert property (1'b1 |=> pin == (raw ^ $past(invert_in)))
    else $error("polarity mismatch");
  disabled_low_a: assert property (!enable_in |=> !raw)
    else $error("disabled channel active");
endmodule

// >>> core/tpw_top.sv
`timescale 1ns/1ps
// Contract
// - Each output has 10-bit duty resolution, one shared period and its own duty value.
// - Every enabled output with a nonzero duty value goes active when the timebase clears at a period start.
// - An output goes inactive when the timebase equals its buffered 10-bit duty value.
// - A duty value beyond the last timebase count never clears the output (100% duty).
// - Duty high and low registers are copied to the buffer only at the period match.
// - The polarity bit of a channel inverts that channel's output.
// - The period is (period_reg + 1) times four system clocks times the prescale ratio.
// - After the match the timebase clears, outputs go active, duty is latched; 0% stays low.
// - The postscaler only paces the match flag and never touches the waveform.
// - The 10-bit timebase is the 8-bit count plus two prescaled system-clock bits.
// - Duty registers accept writes at any time without disturbing the buffered value.
module tpw_top #(
  parameter int NUM_CH = tpw_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  // APB slave
  input  wire logic [7:0]        paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic [31:0]            prdata_out,
  output logic                   pslverr_out,
  // PWM outputs and status
  output logic [NUM_CH-1:0]      pwm_out,
  output logic                   timebase_match_flag_out
);
  logic [7:0]        period_reg;
  logic [7:0]        next_period_reg;
  logic [7:0]        timebase_control_reg;
  logic [7:0]        next_timebase_control_reg;
  logic              timebase_match_flag;
  logic              next_timebase_match_flag;
  logic [3:0]        post_cnt;
  logic [3:0]        next_post_cnt;
  logic [7:0]        channel_control_reg [NUM_CH];
  logic [7:0]        next_channel_control_reg [NUM_CH];
  logic [7:0]        duty_high_reg [NUM_CH];
  logic [7:0]        next_duty_high_reg [NUM_CH];
  logic [7:0]        duty_low_reg [NUM_CH];
  logic [7:0]        next_duty_low_reg [NUM_CH];
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic              slverr;
  logic              next_slverr;
  logic [NUM_CH-1:0] raw_state;
  logic              wr_en;
  logic              setup;

  tpw_tb_if tb_bus ();

  // Channel register address match
  function automatic logic ch_addr(input logic [7:0] a, input int c, input logic [7:0] ofs);
    logic [7:0] base;
    base = 8'(tpw_pkg::ADDR_CH_BASE + 8'(c) * tpw_pkg::CH_STRIDE + ofs);
    return a == base;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    logic hit;
    hit = (a == tpw_pkg::ADDR_PERIOD) || (a == tpw_pkg::ADDR_TB_CTRL)
       || (a == tpw_pkg::ADDR_TB_COUNT) || (a == tpw_pkg::ADDR_FLAG);
    for (int c = 0; c < NUM_CH; c++) begin
      hit = hit || ch_addr(a, c, tpw_pkg::OFS_CTRL) || ch_addr(a, c, tpw_pkg::OFS_DUTY_HI)
        || ch_addr(a, c, tpw_pkg::OFS_DUTY_LO);
    end
    return hit;
  endfunction

  // Zero-wait access; read data captured during setup
  assign setup      = psel_in && !penable_in;
  assign wr_en      = psel_in && penable_in && pwrite_in;
  assign pready_out = 1'b1;

  always_comb begin
    next_period_reg           = period_reg;
    next_timebase_control_reg = timebase_control_reg;
    for (int c = 0; c < NUM_CH; c++) begin
      next_channel_control_reg[c] = channel_control_reg[c];
      next_duty_high_reg[c]       = duty_high_reg[c];
      next_duty_low_reg[c]        = duty_low_reg[c];
    end
    if (wr_en) begin
      if (paddr_in == tpw_pkg::ADDR_PERIOD) begin
        next_period_reg = pwdata_in[7:0];
      end
      if (paddr_in == tpw_pkg::ADDR_TB_CTRL) begin
        next_timebase_control_reg = pwdata_in[7:0];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (ch_addr(paddr_in, c, tpw_pkg::OFS_CTRL)) begin
          next_channel_control_reg[c] = pwdata_in[7:0];
        end
        if (ch_addr(paddr_in, c, tpw_pkg::OFS_DUTY_HI)) begin
          next_duty_high_reg[c] = pwdata_in[7:0];
        end
        if (ch_addr(paddr_in, c, tpw_pkg::OFS_DUTY_LO)) begin
          next_duty_low_reg[c] = {pwdata_in[tpw_pkg::DLO_MSB:tpw_pkg::DLO_LSB], 6'h00};
        end
      end
    end
  end

  // Match flag paced by postscaler; set wins over a clear write
  always_comb begin
    next_post_cnt            = post_cnt;
    next_timebase_match_flag = timebase_match_flag;
    if (wr_en && paddr_in == tpw_pkg::ADDR_FLAG && pwdata_in[tpw_pkg::FLAG_BIT]) begin
      next_timebase_match_flag = 1'b0;
    end
    if (tb_bus.start) begin
      if (post_cnt == timebase_control_reg[tpw_pkg::POST_MSB:tpw_pkg::POST_LSB]) begin
        next_post_cnt            = 4'h0;
        next_timebase_match_flag = 1'b1;
      end else begin
        next_post_cnt = post_cnt + 4'h1;
      end
    end
  end

  always_comb begin
    next_rdata  = rdata;
    next_slverr = slverr;
    if (setup) begin
      next_rdata  = 32'h0000_0000;
      next_slverr = !mapped(paddr_in);
      if (paddr_in == tpw_pkg::ADDR_PERIOD) begin
        next_rdata[7:0] = period_reg;
      end
      if (paddr_in == tpw_pkg::ADDR_TB_CTRL) begin
        next_rdata[7:0] = timebase_control_reg;
      end
      if (paddr_in == tpw_pkg::ADDR_TB_COUNT) begin
        next_rdata[7:0] = tb_bus.count[tpw_pkg::DUTY_W-1:tpw_pkg::TB_LO_W];
      end
      if (paddr_in == tpw_pkg::ADDR_FLAG) begin
        next_rdata[tpw_pkg::FLAG_BIT] = timebase_match_flag;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (ch_addr(paddr_in, c, tpw_pkg::OFS_CTRL)) begin
          next_rdata[7:0] = channel_control_reg[c];
          next_rdata[tpw_pkg::STATE_BIT] = raw_state[c];
        end
        if (ch_addr(paddr_in, c, tpw_pkg::OFS_DUTY_HI)) begin
          next_rdata[7:0] = duty_high_reg[c];
        end
        if (ch_addr(paddr_in, c, tpw_pkg::OFS_DUTY_LO)) begin
          next_rdata[7:0] = duty_low_reg[c];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      period_reg           <= tpw_pkg::PERIOD_RST;
      timebase_control_reg <= tpw_pkg::TB_CTRL_RST;
      timebase_match_flag  <= 1'b0;
      post_cnt             <= 4'h0;
      rdata                <= 32'h0000_0000;
      slverr               <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        channel_control_reg[c] <= tpw_pkg::CH_CTRL_RST;
        duty_high_reg[c]       <= tpw_pkg::DUTY_RST;
        duty_low_reg[c]        <= tpw_pkg::DUTY_RST;
      end
    end else begin
      period_reg           <= next_period_reg;
      timebase_control_reg <= next_timebase_control_reg;
      timebase_match_flag  <= next_timebase_match_flag;
      post_cnt             <= next_post_cnt;
      rdata                <= next_rdata;
      slverr               <= next_slverr;
      for (int c = 0; c < NUM_CH; c++) begin
        channel_control_reg[c] <= next_channel_control_reg[c];
        duty_high_reg[c]       <= next_duty_high_reg[c];
        duty_low_reg[c]        <= next_duty_low_reg[c];
      end
    end
  end

  assign prdata_out              = rdata;
  assign pslverr_out             = slverr && psel_in && penable_in;
  assign timebase_match_flag_out = timebase_match_flag;

  // One shared timebase for every channel
  tpw_timebase u_timebase (
    .ref_clk_in   (ref_clk_in),
    .srst_in      (srst_in),
    .run_in       (timebase_control_reg[tpw_pkg::RUN_BIT]),
    .presc_sel_in (timebase_control_reg[tpw_pkg::PRESC_MSB:tpw_pkg::PRESC_LSB]),
    .period_in    (period_reg),
    .tb           (tb_bus.src)
  );

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    tpw_channel u_channel (
      .ref_clk_in   (ref_clk_in),
      .srst_in      (srst_in),
      .enable_in    (channel_control_reg[g][tpw_pkg::EN_BIT]),
      .invert_in    (channel_control_reg[g][tpw_pkg::INV_BIT]),
      .duty_high_in (duty_high_reg[g]),
      .duty_low_in  (duty_low_reg[g][tpw_pkg::DLO_MSB:tpw_pkg::DLO_LSB]),
      .period_in    (period_reg),
      .tb           (tb_bus.snk),
      .raw_out      (raw_state[g]),
      .pwm_out      (pwm_out[g])
    );
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  period_write_a: assert property (wr_en && paddr_in == tpw_pkg::ADDR_PERIOD
    |=> period_reg == $past(pwdata_in[7:0]))
    else $error("period write lost");
  flag_set_wins_a: assert property (tb_bus.start
    && post_cnt == timebase_control_reg[tpw_pkg::POST_MSB:tpw_pkg::POST_LSB]
    |=> timebase_match_flag)
    else $error("match flag not set");
endmodule

// >>> verification/tb_timer_based_pwm_generator.sv
`timescale 1ns/1ps
module tb_timer_based_pwm_generator;
  logic        ref_clk_in;
  logic        srst_in;
  logic [7:0]  paddr_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [31:0] pwdata_in;
  logic        pready_out;
  logic [31:0] prdata_out;
  logic        pslverr_out;
  logic [1:0]  pwm_out;
  logic        timebase_match_flag_out;
  int          fail_count;
  int          compares;
  int          seed;

  initial begin
    ref_clk_in = 1'h0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  tpw_top #(.NUM_CH(2)) u_tpw_top (
    .ref_clk_in              (ref_clk_in),
    .srst_in                 (srst_in),
    .paddr_in                (paddr_in),
    .psel_in                 (psel_in),
    .penable_in              (penable_in),
    .pwrite_in               (pwrite_in),
    .pwdata_in               (pwdata_in),
    .pready_out              (pready_out),
    .prdata_out              (prdata_out),
    .pslverr_out             (pslverr_out),
    .pwm_out                 (pwm_out),
    .timebase_match_flag_out (timebase_match_flag_out)
  );

  task automatic complete_run;
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic check_count(input string name, input int exp, input int got);
    compares++;
    if (got != exp) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb_xfer(input logic [7:0] addr, input logic wr, input logic [7:0] wdata,
                          output logic [31:0] rdata, output logic err);
    int n;
    @(posedge ref_clk_in);
    paddr_in   <= addr;
    pwrite_in  <= wr;
    pwdata_in  <= {24'h000000, wdata};
    psel_in    <= 1'h1;
    penable_in <= 1'h0;
    @(posedge ref_clk_in);
    penable_in <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      complete_run();
    end
    rdata = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [31:0] d;
    logic        e;
    apb_xfer(addr, 1'h1, data, d, e);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err,
                        input string name);
    logic [31:0] d;
    logic        e;
    apb_xfer(addr, 1'h0, 8'h00, d, e);
    check_val(name, exp, d);
    check_val(name, {31'h0, exp_err}, {31'h0, e});
  endtask

  function automatic logic [7:0] chaddr(input logic ch, input logic [7:0] ofs);
    return ch ? tpw_pkg::ADDR_CH_BASE + tpw_pkg::CH_STRIDE + ofs : tpw_pkg::ADDR_CH_BASE + ofs;
  endfunction

  // High cycles in one period, full period once duty passes the last count
  function automatic int exp_high(input int per, input int duty, input int ratio, input logic inv);
    int lim;
    int h;
    lim = 4 * (per + 1);
    h = (duty < lim ? duty : lim) * ratio;
    return inv ? lim * ratio - h : h;
  endfunction

  task automatic do_reset;
    @(posedge ref_clk_in);
    srst_in <= 1'h1;
    repeat (3) @(posedge ref_clk_in);
    srst_in <= 1'h0;
  endtask

  // Clear the sticky flag, then wait for the next postscaled match flag
  task automatic wait_flag;
    int n;
    wr(tpw_pkg::ADDR_FLAG, 8'h01);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (timebase_match_flag_out !== 1'h1 && n < 5000);
    if (n >= 5000) begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic measure(input int len, output int h0, output int h1);
    h0 = 0;
    h1 = 0;
    repeat (len) begin
      @(negedge ref_clk_in);
      h0 += (pwm_out[0] === 1'h1);
      h1 += (pwm_out[1] === 1'h1);
    end
  endtask

  initial begin
    logic [7:0] per;
    logic [9:0] d0;
    logic [9:0] d1;
    logic [2:0] post;
    logic       ps;
    logic       inv;
    logic       en1;
    int         lim;
    int         ratio;
    int         h0;
    int         h1;
    seed = 83;
    fail_count = 0;
    compares = 0;
    srst_in = 1'h1;
    paddr_in = 8'h00;
    psel_in = 1'h0;
    penable_in = 1'h0;
    pwrite_in = 1'h0;
    pwdata_in = 32'h00000000;
    for (int r = 0; r < 8; r++) begin
      do_reset();
      @(negedge ref_clk_in);
      check_val("pwm_reset", 32'h0, {30'h0, pwm_out});
      rd_chk(tpw_pkg::ADDR_PERIOD, {24'h0, tpw_pkg::PERIOD_RST}, 1'h0, "period_rst");
      rd_chk(chaddr(1'h0, tpw_pkg::OFS_DUTY_HI), 32'h0, 1'h0, "duty_rst");
      rd_chk(8'hFC, 32'h0, 1'h1, "unmapped");
      per = 8'($unsigned($random(seed)) % 8);
      post = 3'($random(seed));
      ps = r[0];
      inv = 1'($random(seed));
      en1 = (r != 3);
      ratio = ps ? 4 : 1;
      lim = 4 * (per + 1);
      d0 = 10'($unsigned($random(seed)) % (lim + 3));
      d1 = 10'($unsigned($random(seed)) % (lim + 3));
      // Corners: 0%, last count, first 100% value
      if (r == 0) d0 = 10'h000;
      if (r == 1) d0 = 10'(lim - 1);
      if (r == 2) d0 = 10'(lim);
      wr(chaddr(1'h0, tpw_pkg::OFS_CTRL), 8'h00);
      wr(chaddr(1'h1, tpw_pkg::OFS_CTRL), 8'h00);
      wr(tpw_pkg::ADDR_PERIOD, per);
      wr(chaddr(1'h0, tpw_pkg::OFS_DUTY_HI), d0[9:2]);
      wr(chaddr(1'h0, tpw_pkg::OFS_DUTY_LO), {d0[1:0], 6'h3F});
      wr(chaddr(1'h1, tpw_pkg::OFS_DUTY_HI), d1[9:2]);
      wr(chaddr(1'h1, tpw_pkg::OFS_DUTY_LO), {d1[1:0], 6'h15});
      wr(tpw_pkg::ADDR_TB_COUNT, 8'($random(seed)));
      wr(tpw_pkg::ADDR_TB_CTRL, {1'h0, 1'h0, post, 1'h1, 1'h0, ps});
      wait_flag();
      // Pin direction lives outside the block; outputs are observed directly
      wr(chaddr(1'h0, tpw_pkg::OFS_CTRL), 8'h80);
      wr(chaddr(1'h1, tpw_pkg::OFS_CTRL), {en1, 2'h0, inv, 4'h0});
      wait_flag();
      wait_flag();
      rd_chk(chaddr(1'h0, tpw_pkg::OFS_DUTY_LO), {24'h0, d0[1:0], 6'h00}, 1'h0, "duty_lo_rd");
      rd_chk(tpw_pkg::ADDR_PERIOD, {24'h0, per}, 1'h0, "period_rd");
      measure(lim * ratio, h0, h1);
      check_count("ch0_high", exp_high(per, d0, ratio, 1'h0), h0);
      check_count("ch1_high", exp_high(per, en1 ? d1 : 0, ratio, inv), h1);
      measure(3 * lim * ratio, h0, h1);
      check_count("ch0_high3", 3 * exp_high(per, d0, ratio, 1'h0), h0);
      check_count("ch1_high3", 3 * exp_high(per, en1 ? d1 : 0, ratio, inv), h1);
    end
    complete_run();
  end
endmodule
